/* hw/pmf_top.sv */
// Pre-driver command decoder, deadtime control and fault latch status.
// Assumes sys_clk is the internal time base; sclk stands still outside frames.
// Summary of operation
// [R1] Top bits 010 is mode: bit3 fault mode, bit1 simultaneous, bit0 lock.
// [R2] Lock stays set once set; only device reset clears it.
// [R3] Locked: mode, deadtime and mask writes ignored, write error raised.
// [R4] Simultaneous drive: no deadtime or interlock, inputs drive outputs.
// [R5] Simultaneous drive resets off; then deadtime and interlock enforced.
// [R6] Fault mode 0: saturation or phase error switches all drivers off.
// [R7] Fault mode 1: no shutdown on those errors, flags still raised.
// [R8] Mode bits and lock in one command: apply mode, then lock.
// [R9] Per-phase timer from turn-off gates turn-on of opposite FET.
// [R10] Calibrate command, then chip-select pulse counted and divided by 16.
// [R11] Zero-deadtime command sets zero; interlock still applies.
// [R12] Deadtime resets to 255 cycles until a deadtime command.
// [R13] Data ignored during calibration pulse; clock edges give framing error.
// [R14] A command returns a status byte unless it follows a read of register 1 to 3; reads select registers 0 to 3.
// [R15] Status flags latch; cleared only by clear command if cause gone.
// [R16] Status bit 0 is OR of the three thermal limit detectors.
// [R17] Status bit 1 is OR of saturation detectors and phase errors.
// [R18] Status bit 4 latches phase comparator mismatch, single side on.
// [R19] Status bit 5 latches bad bit count frames or calibration clocks.
// [R20] Status bit 6 latches locked writes and undefined commands.
// [R21] Bit 2 low gate supply, bit 3 overcurrent; mask gates interrupt.
// [R22] Status bit 7 set out of reset; status resets to 80h.
// [R23] Clear commands clear named flags at frame end, valid unchanged frames.
// [R24] Mask commands load two enable nibbles, both resetting to ones.
// [R25] Interrupt high while any enabled latched flag remains.
// [R26] Calibration counter saturates instead of wrapping.
`timescale 1ns/1ns
module pmf_top (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // SPI pins
  input  wire logic                     sclk,
  input  wire logic                     csn,
  input  wire logic                     si,
  output logic                          miso,
  output logic                          miso_oe_n,
  // Phase commands and enable
  input  wire logic                     drv_en,
  input  wire logic [pmf_pkg::NPH-1:0]  hs_cmd,
  input  wire logic [pmf_pkg::NPH-1:0]  ls_cmd,
  // Fault sensing
  input  wire logic [pmf_pkg::NPH-1:0]  phase_node,
  input  wire logic [pmf_pkg::NPH-1:0]  thermal_limit,
  input  wire logic [pmf_pkg::NPH-1:0]  saturation_loss,
  input  wire logic                     gate_supply_low,
  input  wire logic                     overcurrent,
  // Gate drive and interrupt
  output logic      [pmf_pkg::NPH-1:0]  hs_drv,
  output logic      [pmf_pkg::NPH-1:0]  ls_drv,
  output logic                          irq
);
  import pmf_pkg::*;

  localparam int unsigned SW = 4 + 5 * NPH;
  // Synchroniser idle: chip select high, every other pin low
  localparam logic [SW-1:0] S_IDLE = {1'b1, {(SW-1){1'b0}}};

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  pmf_link_if lnk ();

  logic [SW-1:0]    s1_q;
  logic [SW-1:0]    s2_q;
  logic [CNT_W-1:0] g1_q;
  logic [CNT_W-1:0] g2_q;
  logic             csn_s;
  logic             en_s;
  logic             prev_q;
  logic [NPH-1:0]   hs_s;
  logic [NPH-1:0]   ls_s;
  logic [NPH-1:0]   ph_s;
  logic [NPH-1:0]   th_s;
  logic [NPH-1:0]   sat_s;
  logic             gsl_s;
  logic             oc_s;
  logic             fall;
  logic             rise;
  logic [CNT_W-1:0] cnt_now;
  logic [CNT_W-1:0] start_q;
  logic [CNT_W-1:0] nbits;
  logic             frame_ok;
  logic [7:0]       rx;
  logic [7:0]       tx_q;
  logic [2:0]       base_q;
  logic             hold_q;
  pmf_cal_e         cal_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic [DT_W-1:0]  dead_q;
  logic             cal_done_q;
  logic             ovf_q;
  logic             zero_q;
  logic             lock_q;
  logic             full_q;
  logic             fmode_q;
  logic             shut_q;
  logic [7:0]       mask_q;
  logic [7:0]       st_q;
  logic [7:0]       st_d;
  logic [7:0]       st_start_q;
  logic [7:0]       ev;
  logic [7:0]       clr;
  logic             do_read;
  logic             do_mask;
  logic             do_mode;
  logic             do_clear;
  logic             do_dead;
  logic             wr_err;
  logic             frm_err;
  logic             run;
  logic [NPH-1:0]   perr;
  logic [NPH-1:0]   hs_q;
  logic [NPH-1:0]   ls_q;
  logic [NPH-1:0]   hs_d;
  logic [NPH-1:0]   ls_d;
  logic [DT_W-1:0]  timer_q [NPH];

  // Shifter on the serial clock
  pmf_spi_link u_link (
    .sclk   (sclk),
    .resetn (resetn),
    .si     (si),
    .miso   (miso),
    .lnk    (lnk)
  );

  assign miso_oe_n = csn;

  // Two-stage synchronisers for pins and the gray edge count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= S_IDLE;
      s2_q <= S_IDLE;
      g1_q <= 8'h00;
      g2_q <= 8'h00;
    end else begin
      s1_q <= {csn, drv_en, hs_cmd, ls_cmd, phase_node, thermal_limit,
               saturation_loss, gate_supply_low, overcurrent};
      s2_q <= s1_q;
      g1_q <= lnk.cnt_gray;
      g2_q <= g1_q;
    end
  end

  assign {csn_s, en_s, hs_s, ls_s, ph_s, th_s, sat_s, gsl_s, oc_s} = s2_q;

  // Frame edges and bit count of the frame
  assign fall     = prev_q & ~csn_s;
  assign rise     = ~prev_q & csn_s;
  assign cnt_now  = gray2bin(g2_q);
  assign nbits    = cnt_now - start_q;
  assign frame_ok = (nbits != 8'h00) && (nbits[2:0] == 3'h0);
  assign rx       = lnk.rx_byte;

  // Frame start snapshots
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q     <= 1'b1;
      start_q    <= 8'h00;
      st_start_q <= ST0_RESET;
    end else begin
      prev_q <= csn_s;
      if (fall) begin
        start_q    <= cnt_now;
        st_start_q <= st_q;
      end
    end
  end

  // Command decode at the end of a normal frame
  always_comb begin
    do_read  = 1'b0;
    do_mask  = 1'b0;
    do_mode  = 1'b0;
    do_clear = 1'b0;
    do_dead  = 1'b0;
    wr_err   = 1'b0;
    if (rise && cal_q == PMF_CAL_IDLE && frame_ok) begin
      case (rx[7:5])
        OP_READ:  do_read = 1'b1;
        OP_MASK:  if (lock_q) wr_err = 1'b1; // R3
                  else do_mask = 1'b1;
        OP_MODE:  if (rx[NIB_SEL] || rx[MODE_RSVD]) wr_err = 1'b1; // R1
                  else if (lock_q) wr_err = 1'b1; // R3
                  else do_mode = 1'b1;
        OP_CLEAR: do_clear = 1'b1;
        OP_DEAD:  if (lock_q) wr_err = 1'b1; // R3
                  else do_dead = 1'b1;
        default:  wr_err = 1'b1; // R20
      endcase
    end
  end

  // Bad bit count, or serial clock edges inside a calibration pulse
  assign frm_err = rise && ((cal_q == PMF_CAL_IDLE && !frame_ok) || // R19
                   (cal_q == PMF_CAL_RUN && nbits != 8'h00)); // R13

  // Mode bits; lock can only be set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_q  <= 1'b0;
      full_q  <= 1'b0; // R5
      fmode_q <= 1'b0;
    end else if (do_mode) begin
      fmode_q <= rx[MODE_FAULT]; // R1
      full_q  <= rx[MODE_FULL]; // R8
      lock_q  <= lock_q | rx[MODE_LOCK]; // R2
    end
  end

  // Interrupt enable nibbles
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= MASK_RESET; // R24
    end else if (do_mask) begin
      if (rx[NIB_SEL]) mask_q[7:4] <= rx[3:0]; // R24
      else mask_q[3:0] <= rx[3:0];
    end
  end

  // Deadtime calibration sequence
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cal_q      <= PMF_CAL_IDLE;
      cal_cnt_q  <= '0;
      dead_q     <= DT_RESET; // R12
      cal_done_q <= 1'b0;
      ovf_q      <= 1'b0;
      zero_q     <= 1'b0;
    end else begin
      unique case (cal_q)
        PMF_CAL_IDLE: begin
          if (do_dead && rx[DEAD_CAL]) begin
            cal_q <= PMF_CAL_WAIT; // R10
          end else if (do_dead) begin
            dead_q     <= '0; // R11
            zero_q     <= 1'b1;
            ovf_q      <= 1'b0;
            cal_done_q <= 1'b1;
          end
        end
        PMF_CAL_WAIT: begin
          cal_cnt_q <= '0;
          if (fall) cal_q <= PMF_CAL_RUN;
        end
        PMF_CAL_RUN: begin
          if (!csn_s && cal_cnt_q != CAL_MAX) begin
            cal_cnt_q <= cal_cnt_q + 12'h001; // R26
          end
          if (rise) begin
            dead_q     <= DT_W'(cal_cnt_q >> CAL_DIV); // R10
            ovf_q      <= (cal_cnt_q == CAL_MAX);
            zero_q     <= 1'b0;
            cal_done_q <= 1'b1;
            cal_q      <= PMF_CAL_IDLE;
          end
        end
      endcase
    end
  end

  // Fault events, per-bit clear and latch with set over clear
  always_comb begin
    ev           = 8'h00;
    ev[ST_TEMP]  = |th_s; // R16
    ev[ST_SAT]   = (|sat_s) | (|perr); // R17
    ev[ST_SUPP]  = gsl_s; // R21
    ev[ST_OVC]   = oc_s; // R21
    ev[ST_PHASE] = |perr; // R18
    ev[ST_FRAME] = frm_err; // R19
    ev[ST_WRITE] = wr_err; // R20
    clr = 8'h00;
    if (do_clear) begin
      clr = rx[NIB_SEL] ? {rx[3:0], 4'h0} : {4'h0, rx[3:0]}; // R23
      clr = clr & ~(st_q ^ st_start_q); // R23
    end
    st_d = ev | (st_q & ~clr); // R15
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST0_RESET; // R22
    end else begin
      st_q <= st_d;
    end
  end

  assign irq = |(st_q & mask_q); // R25

  // Reply word: status at frame start unless register 1 to 3 was just read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_q   <= ST0_RESET;
      base_q <= 3'h0;
      hold_q <= 1'b0;
    end else if (rise) begin
      base_q <= cnt_now[2:0];
      hold_q <= do_read && (rx[1:0] != 2'h0);
      tx_q   <= st_d; // R14
      if (do_read) begin
        unique case (rx[1:0])
          2'h0: tx_q <= st_d;
          2'h1: tx_q <= {1'b0, fmode_q, zero_q, ovf_q, cal_done_q, 1'b0,
                         full_q, lock_q};
          2'h2: tx_q <= mask_q;
          2'h3: tx_q <= cal_done_q ? dead_q : 8'h00;
        endcase
      end
    end else if (fall && !hold_q) begin
      tx_q <= st_q; // R14
    end
  end

  assign lnk.tx_word = tx_q;
  assign lnk.tx_base = base_q;

  // Global shutdown in fault mode 0, released by a clear command
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shut_q <= 1'b0;
    end else if (!fmode_q && ((|sat_s) || (|perr))) begin
      shut_q <= 1'b1; // R6
    end else if (do_clear) begin
      shut_q <= 1'b0; // R7
    end
  end

  assign run = en_s & ~shut_q;

  // Per-phase interlock, deadtime timer and phase check
  for (genvar i = 0; i < NPH; i++) begin : g_ph
    logic done;
    assign done = (timer_q[i] == '0);
    always_comb begin
      if (full_q) begin
        hs_d[i] = run & hs_s[i]; // R4
        ls_d[i] = run & ls_s[i]; // R4
      end else begin
        hs_d[i] = run & hs_s[i] & ~ls_q[i] & (hs_q[i] | (done & ~ls_s[i]));
        ls_d[i] = run & ls_s[i] & ~hs_q[i] & (ls_q[i] | (done & ~hs_s[i]));
      end
    end
    assign perr[i] = ~full_q & (hs_q[i] ^ ls_q[i]) & done &
                     (ph_s[i] ^ hs_q[i]); // R18
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        hs_q[i]    <= 1'b0;
        ls_q[i]    <= 1'b0;
        timer_q[i] <= '0;
      end else begin
        hs_q[i] <= hs_d[i];
        ls_q[i] <= ls_d[i];
        if (hs_d[i] != hs_q[i] || ls_d[i] != ls_q[i]) begin
          timer_q[i] <= dead_q; // R9
        end else if (!done) begin
          timer_q[i] <= timer_q[i] - 8'h01;
        end
      end
    end
  end

  assign hs_drv = hs_q;
  assign ls_drv = ls_q;

  // Checks
  a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    lock_q |=> lock_q) else $error("lock bit cleared"); // R2
  a_locked_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    (lock_q && rise && cal_q == PMF_CAL_IDLE && frame_ok &&
     rx[7:5] == OP_MODE) |=> ($stable(full_q) && st_q[ST_WRITE]))
    else $error("locked mode write not refused"); // R3
  a_no_overlap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!full_q && !$past(full_q)) |-> ((hs_q & ls_q) == 3'h0))
    else $error("both drivers of a phase on"); // R5
  a_full_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
    (full_q && run) |=> (hs_q == $past(hs_s)) || !$past(full_q))
    else $error("simultaneous drive not following input"); // R4
  a_dead_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(ls_q[0]) && !full_q) |-> ($past(timer_q[0]) == 8'h00))
    else $error("turn-on before deadtime expired"); // R9
  a_cal_store: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cal_q == PMF_CAL_RUN && rise) |=> dead_q == $past(cal_cnt_q[11:4]))
    else $error("calibrated deadtime wrong"); // R10
  a_zero_dead: assert property (@(posedge sys_clk) disable iff (!resetn)
    (do_dead && !rx[DEAD_CAL]) |=> (dead_q == 8'h00))
    else $error("zero deadtime not applied"); // R11
  a_status_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !do_clear |=> ((st_q & $past(st_q)) == $past(st_q)))
    else $error("status flag lost without clear"); // R15
  a_irq_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (irq && !do_clear && !do_mask) |=> irq)
    else $error("interrupt dropped while pending"); // R25
  a_shutdown: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!fmode_q && (|sat_s)) ##1 !do_clear |=> ((hs_q | ls_q) == 3'h0))
    else $error("drivers not shut down"); // R6
  a_frame_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rise && cal_q == PMF_CAL_IDLE && !frame_ok) |=> st_q[ST_FRAME])
    else $error("framing error not latched"); // R19
endmodule

/* include/pmf_pkg.sv */
// Constants and types shared by the pre-driver command and fault logic.
// Assumes the time-base clock is the core clock and SPI runs on its own clock.
package pmf_pkg;

  // Phase count and datapath widths
  localparam int unsigned NPH     = 3;
  localparam int unsigned DT_W    = 8;
  localparam int unsigned CAL_W   = 12;
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned CAL_DIV = 4;

  // Reset values and calibration count limit
  localparam logic [7:0]       DT_RESET   = 8'hFF;
  localparam logic [7:0]       ST0_RESET  = 8'h80;
  localparam logic [7:0]       MASK_RESET = 8'hFF;
  localparam logic [CAL_W-1:0] CAL_MAX    = 12'hFFF;

  // Command opcodes in the top three bits of a byte
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_MASK  = 3'h1;
  localparam logic [2:0] OP_MODE  = 3'h2;
  localparam logic [2:0] OP_CLEAR = 3'h3;
  localparam logic [2:0] OP_DEAD  = 3'h4;

  // Command field positions
  localparam int unsigned MODE_LOCK  = 0;
  localparam int unsigned MODE_FULL  = 1;
  localparam int unsigned MODE_RSVD  = 2;
  localparam int unsigned MODE_FAULT = 3;
  localparam int unsigned NIB_SEL    = 4;
  localparam int unsigned DEAD_CAL   = 0;

  // Fault latch status bit positions
  localparam int unsigned ST_TEMP  = 0;
  localparam int unsigned ST_SAT   = 1;
  localparam int unsigned ST_SUPP  = 2;
  localparam int unsigned ST_OVC   = 3;
  localparam int unsigned ST_PHASE = 4;
  localparam int unsigned ST_FRAME = 5;
  localparam int unsigned ST_WRITE = 6;
  localparam int unsigned ST_RESET = 7;

  // Deadtime calibration sequencing
  typedef enum logic [1:0] {
    PMF_CAL_IDLE,
    PMF_CAL_WAIT,
    PMF_CAL_RUN
  } pmf_cal_e;

endpackage

/* include/pmf_link_if.sv */
// Bundle between the SPI-clock shifter and the time-base core.
// Only cnt_gray is gray coded; rx_byte is held still while the link clock is idle, tx_word and tx_base while it runs.
`timescale 1ns/1ns
interface pmf_link_if;
  logic [7:0] cnt_gray;
  logic [7:0] rx_byte;
  logic [7:0] tx_word;
  logic [2:0] tx_base;

  modport link (output cnt_gray, output rx_byte, input tx_word,
                input tx_base);
  modport core (input cnt_gray, input rx_byte, output tx_word,
                output tx_base);
endinterface

/* hw/pmf_spi_link.sv */
// SPI shifter on the serial clock: counts edges, gathers bytes, sends reply.
// Assumes tx_word and tx_base stay still from the first serial edge on.
`timescale 1ns/1ns
module pmf_spi_link (
  // Serial clock and reset
  input  wire logic      sclk,
  input  wire logic      resetn,
  // Serial data
  input  wire logic      si,
  output logic           miso,
  // Core side
  pmf_link_if.link       lnk
);
  import pmf_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] gray_q;
  logic [6:0]       shift_q;
  logic [7:0]       rx_q;
  logic [2:0]       idx;

  // Bit position within the current byte, relative to the frame start
  assign idx   = cnt_q[2:0] - lnk.tx_base;
  assign cnt_d = cnt_q + 8'h01;

  // Free-running edge count, published gray coded for the crossing
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 8'h00;
      gray_q <= 8'h00;
    end else begin
      cnt_q  <= cnt_d;
      gray_q <= cnt_d ^ (cnt_d >> 1);
    end
  end

  // Receive shift, whole byte captured on its eighth bit
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 7'h00;
      rx_q    <= 8'h00;
    end else begin
      shift_q <= {shift_q[5:0], si};
      if (idx == 3'h7) begin
        rx_q <= {shift_q, si};
      end
    end
  end

  // Reply MSB first
  assign miso         = lnk.tx_word[3'h7 - idx];
  assign lnk.cnt_gray = gray_q;
  assign lnk.rx_byte  = rx_q;
endmodule

/* dv/pmf_host.sv */
// Host model: SPI master for the pre-driver's serial command port.
// Assumes the bench calls its tasks; link clock 80 ns, idle low.
`timescale 1ns/1ns
module pmf_host (
  // Serial pins
  output logic      sclk,
  output logic      csn,
  output logic      si,
  input  wire logic miso
);
  // Idle levels
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    si   = 1'b0;
  end
  // One frame of nb bits, MSB first; reply taken before each rising edge
  task automatic xfer(input logic [7:0] cmd, input int nb,
                      output logic [7:0] rep);
    rep = 8'h00;
    #7 csn = 1'b0;
    #200;
    for (int i = nb - 1; i >= 0; i--) begin
      si = cmd[i % 8];
      #40 rep = {rep[6:0], miso};
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    // Released data line shows the inverse of the last bit
    si = ~si;
    #80 csn = 1'b1;
    #200;
  endtask
  // Chip-select pulse of nc time-base periods, optional stray clock
  task automatic pulse(input int nc, input bit wig);
    #7 csn = 1'b0;
    #(nc * 20);
    if (wig) begin
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end else begin
      #40;
    end
    #(nc * 20 - 40) csn = 1'b1;
    #200;
  endtask
endmodule

/* dv/tb_pmf_top.sv */
// Bench for the pre-driver command, deadtime and fault latch logic.
// Assumes pmf_host drives the serial pins; phase node follows high side.
`timescale 1ns/1ns
module tb_pmf_top;
  import pmf_pkg::*;
  // Bench signals
  logic           sys_clk = 1'b0;
  logic           resetn  = 1'b0;
  logic           drv_en  = 1'b0;
  logic           gsl     = 1'b0;
  logic           ovc     = 1'b0;
  logic           bad_ph  = 1'b0;
  logic           sclk, csn, si, miso, miso_oe_n, irq;
  logic [NPH-1:0] hs_cmd = '0, ls_cmd = '0, pn = '0, tl = '0, sat = '0;
  logic [NPH-1:0] hs_drv, ls_drv;
  logic [7:0]     r;
  int             err_count   = 0;
  int             checks_done = 0;
  int             cyc         = 0;

  // Clock, phase node model and hang guard
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) pn <= #2 hs_drv ^ {2'b00, bad_ph};
  // Reply pin must be enabled inside every frame
  always @(negedge csn) #100 chk({7'h00, miso_oe_n}, 8'h00);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  pmf_host i_host (.sclk(sclk), .csn(csn), .si(si), .miso(miso));
  pmf_top i_pmf_top (
    .sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .csn(csn),
    .si(si), .miso(miso), .miso_oe_n(miso_oe_n), .drv_en(drv_en),
    .hs_cmd(hs_cmd), .ls_cmd(ls_cmd), .phase_node(pn),
    .thermal_limit(tl), .saturation_loss(sat),
    .gate_supply_low(gsl), .overcurrent(ovc),
    .hs_drv(hs_drv), .ls_drv(ls_drv), .irq(irq));

  // Comparison and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bus helpers
  task automatic cmd(input logic [7:0] c);
    i_host.xfer(c, 8, r);
  endtask
  task automatic st0(input logic [7:0] e);
    i_host.xfer(8'h00, 8, r);
    chk(r, e);
  endtask
  task automatic rd(input logic [1:0] n, input logic [7:0] e);
    i_host.xfer({6'h00, n}, 8, r);
    i_host.xfer(8'h00, 8, r);
    chk(r, e);
  endtask
  // Drive helpers
  task automatic drive(input logic [2:0] h, input logic [2:0] l,
                       input int w);
    @(posedge sys_clk);
    #2 hs_cmd = h;
    ls_cmd = l;
    repeat (w) @(posedge sys_clk);
  endtask
  task automatic flt(input logic [2:0] s, input logic [2:0] t,
                     input logic g, input logic o);
    @(posedge sys_clk);
    #2 {sat, tl, gsl, ovc} = {s, t, g, o};
    repeat (8) @(posedge sys_clk);
    #2 {sat, tl, gsl, ovc} = '0;
    repeat (8) @(posedge sys_clk);
  endtask
  // Cycles from high-side off command to low side on
  task automatic gap(output int n, output logic ov);
    drive(3'h1, 3'h0, 300);
    drive(3'h0, 3'h1, 0);
    n = 0;
    ov = 1'b0;
    while (ls_drv[0] !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 ov = ov | (hs_drv[0] & ls_drv[0]);
      n++;
    end
  endtask

  // Scenarios
  task automatic t_reset();
    int n;
    logic ov;
    chk({7'h00, irq}, 8'h01);
    chk({2'b00, hs_drv, ls_drv}, 8'h00);
    chk({7'h00, miso_oe_n}, 8'h01);
    st0(8'h80);
    gap(n, ov);
    chk({7'h00, n >= 255 && n <= 265}, 8'h01);
    chk({7'h00, ov}, 8'h00);
  endtask
  task automatic t_mask();
    cmd(8'h37);
    chk({7'h00, irq}, 8'h00);
    cmd(8'h3F);
    chk({7'h00, irq}, 8'h01);
    cmd(8'h78);
    st0(8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_err();
    i_host.xfer(8'h00, 5, r);
    st0(8'h20);
    chk({7'h00, irq}, 8'h01);
    cmd(8'hA0);
    st0(8'h60);
    cmd(8'h76);
    cmd(8'h44);
    st0(8'h40);
    cmd(8'h74);
    st0(8'h00);
  endtask
  task automatic t_cal();
    int n;
    logic ov;
    cmd(8'h81);
    i_host.pulse(4200, 1'b0);
    rd(2'h3, 8'hFF);
    st0(8'h00);
    cmd(8'h81);
    i_host.pulse(168, 1'b1);
    st0(8'h20);
    rd(2'h3, 8'h0A);
    gap(n, ov);
    chk({7'h00, n >= 10 && n <= 18}, 8'h01);
    chk({7'h00, ov}, 8'h00);
    cmd(8'h72);
  endtask
  task automatic t_fault();
    drive(3'h1, 3'h0, 40);
    chk({5'h00, hs_drv}, 8'h01);
    flt(3'h2, 3'h0, 1'b0, 1'b0);
    chk({5'h00, hs_drv}, 8'h00);
    st0(8'h02);
    cmd(8'h62);
    repeat (40) @(posedge sys_clk);
    chk({5'h00, hs_drv}, 8'h01);
    st0(8'h00);
    #2 bad_ph = 1'b1;
    repeat (20) @(posedge sys_clk);
    chk({5'h00, hs_drv}, 8'h00);
    st0(8'h12);
    bad_ph = 1'b0;
    cmd(8'h62);
    cmd(8'h71);
    repeat (40) @(posedge sys_clk);
    st0(8'h00);
    flt(3'h0, 3'h4, 1'b1, 1'b1);
    st0(8'h0D);
    cmd(8'h6D);
    st0(8'h00);
    cmd(8'h48);
    flt(3'h1, 3'h0, 1'b0, 1'b0);
    chk({5'h00, hs_drv}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    cmd(8'h62);
  endtask
  task automatic t_zero();
    cmd(8'h80);
    rd(2'h3, 8'h00);
    drive(3'h1, 3'h1, 20);
    chk({5'h00, hs_drv & ls_drv}, 8'h00);
  endtask
  task automatic t_lock();
    cmd(8'h7F);
    cmd(8'h6F);
    cmd(8'h4B);
    drive(3'h1, 3'h1, 20);
    chk({6'h00, hs_drv[0], ls_drv[0]}, 8'h03);
    cmd(8'h40);
    st0(8'h40);
    chk({6'h00, hs_drv[0], ls_drv[0]}, 8'h03);
    cmd(8'h81);
    rd(2'h3, 8'h00);
    cmd(8'h74);
    st0(8'h00);
    cmd(8'h30);
    st0(8'h40);
    chk({7'h00, irq}, 8'h01);
    rd(2'h2, 8'hFF);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #2 resetn = 1'b1;
    drv_en = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_mask();
    t_err();
    t_cal();
    t_fault();
    t_zero();
    t_lock();
    tally_and_finish();
  end
endmodule
